// ==== design/ssra_pkg.sv ====
// Constants, types and behaviour list for the SMBus slave front end with alert logic
// Behaviour
// - Own address received: device acknowledges by pulling data low one clock.
// - After a write-direction address, first byte loads the register pointer.
// - Master sends an 8-bit pointer after address acknowledge; device acknowledges it.
// - Pointer naming no implemented register abandons the current operation.
// - Pointer value is kept between transactions for repeated reads.
// - Data bytes follow pointer; device acknowledges each; master ends with stop.
// - Without repeated start, bytes after pointer are written to selected register.
// - Read data starts clock after acknowledge; master ends with not-acknowledge, stop.
// - Bus held low past timeout returns serial interface to idle.
// - High, low limit alarms per zone, plus open remote diode alarm.
// - Each measurement sets status bits when above high or at/below low limit.
// - Status bits sticky; a read clears only bits whose condition is gone.
// - All alarms combine onto one open-drain active-low alert output.
// - Alert stays low until status clear and an alert response was answered.
// - Configuration mask bit keeps the alert output from asserting.
// - Active alert: acknowledge response address, return own address with LSB one.
// - Lowest address wins; device stops driving when it loses arbitration.
// - Status read with condition gone lets next alert response release the output.
// - Device answers to slave address 58 hex, and to the alert response address 0C hex while alert is active.
package ssra_pkg;

  localparam logic [6:0] OWN_ADDR      = 7'h58;
  localparam logic [6:0] ARA_ADDR      = 7'h0C;
  localparam logic [7:0] ARA_REPLY     = {OWN_ADDR, 1'b1};

  localparam logic [7:0] REG_STATUS    = 8'h02;
  localparam logic [7:0] REG_CONFIG    = 8'h09;
  localparam logic [7:0] REG_CONV      = 8'h0A;
  localparam logic [7:0] REG_Z2_HIGH   = 8'h0B;
  localparam logic [7:0] REG_Z2_LOW    = 8'h0C;
  localparam logic [7:0] REG_Z1_HIGH   = 8'h0D;
  localparam logic [7:0] REG_Z1_LOW    = 8'h0E;
  localparam logic [7:0] REG_Z1_TEMP   = 8'h25;
  localparam logic [7:0] REG_Z2_TEMP   = 8'h26;

  localparam logic [7:0] RST_CONFIG    = 8'h00;
  localparam logic [7:0] RST_CONV      = 8'h08;
  localparam logic [7:0] RST_Z2_HIGH   = 8'h55;
  localparam logic [7:0] RST_Z2_LOW    = 8'h00;
  localparam logic [7:0] RST_Z1_HIGH   = 8'h55;
  localparam logic [7:0] RST_Z1_LOW    = 8'h00;
  localparam logic [7:0] RST_TEMP      = 8'h00;

  localparam int unsigned CFG_MASK_BIT = 7;
  localparam int unsigned STAT_BUSY    = 7;
  // Status flags sit in a 5-bit vector; index i lands on status bit i+2
  localparam int unsigned STAT_LSB     = 2;
  localparam int unsigned FL_ROPEN     = 0;
  localparam int unsigned FL_RLOW      = 1;
  localparam int unsigned FL_RHIGH     = 2;
  localparam int unsigned FL_LLOW      = 3;
  localparam int unsigned FL_LHIGH     = 4;
  localparam int unsigned FL_W         = 5;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned TIMEOUT_MS   = 25;
  localparam int unsigned TIMEOUT_CYC  = TIMEOUT_MS * CLK_MHZ * 1000;

  typedef struct packed {
    logic [9:0] z1_temp;
    logic [9:0] z2_temp;
    logic       diode_open;
    logic       busy;
  } ssra_meas_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_TX, ST_RACK
  } ssra_state_e;

endpackage

// ==== design/ssra_sync.sv ====
// Two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module ssra_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ==== design/ssra_limit_cmp.sv ====
// Signed limit comparison for one temperature zone
`timescale 1ns/1ps
module ssra_limit_cmp (
  input  wire logic [7:0] temp,
  input  wire logic [7:0] high_lim,
  input  wire logic [7:0] low_lim,
  output logic            over_high,
  output logic            at_or_below_low
);
  // Above high limit, or equal to or below low limit
  assign over_high       = $signed(temp) > $signed(high_lim);
  assign at_or_below_low = $signed(temp) <= $signed(low_lim);
endmodule

// ==== design/ssra_top.sv ====
// SMBus slave front end: address match, pointer, register access, alert and response
`timescale 1ns/1ps
module ssra_top #(
  parameter int unsigned TIMEOUT_CYC = ssra_pkg::TIMEOUT_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 scl,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  input  wire logic                 alert_i,
  output logic                      alert_o,
  output logic                      alert_oe,
  input  wire logic                 meas_done,
  input  wire ssra_pkg::ssra_meas_s meas
);

  // ---------------- Link domain: bits captured on the master's clock edge
  logic link_bit_r;
  logic link_tog_r;

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      link_bit_r <= 1'b0;
      link_tog_r <= 1'b0;
    end else begin
      link_bit_r <= sda_i;
      link_tog_r <= ~link_tog_r;
    end
  end

  // ---------------- System domain: pin sampling and bus events
  logic [2:0] sync_q;
  logic       scl_s;
  logic       sda_s;
  logic       tog_s;
  logic       scl_q_r;
  logic       sda_q_r;
  logic       tog_q_r;

  ssra_sync #(.W(3)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({scl, sda_i, link_tog_r}),
    .q     (sync_q)
  );

  assign scl_s = sync_q[2];
  assign sda_s = sync_q[1];
  assign tog_s = sync_q[0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // Match the synchroniser's reset level so no false clock fall follows reset
      scl_q_r <= 1'b0;
      sda_q_r <= 1'b0;
      tog_q_r <= 1'b0;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      tog_q_r <= tog_s;
    end
  end

  logic start_ev;
  logic stop_ev;
  logic scl_fall;
  logic bit_rx;

  assign start_ev = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_ev  = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign scl_fall = scl_q_r & ~scl_s;
  // The captured bit stays stable for a whole link clock period after the toggle
  assign bit_rx   = tog_s ^ tog_q_r;

  // ---------------- Bus-stuck timeout
  logic [31:0] tout_cnt_r;
  logic        tout_ev;

  assign tout_ev = (tout_cnt_r == TIMEOUT_CYC - 1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tout_cnt_r <= '0;
    end else if (scl_s & sda_s) begin
      tout_cnt_r <= '0;
    end else if (!tout_ev) begin
      tout_cnt_r <= tout_cnt_r + 32'd1;
    end
  end

  // ---------------- Register file
  logic [7:0]             cfg_r;
  logic [7:0]             conv_r;
  logic [7:0]             z2_high_r;
  logic [7:0]             z2_low_r;
  logic [7:0]             z1_high_r;
  logic [7:0]             z1_low_r;
  logic [7:0]             z1_temp_r;
  logic [7:0]             z2_temp_r;
  logic [ssra_pkg::FL_W-1:0] stat_r;
  logic [ssra_pkg::FL_W-1:0] cond_r;
  logic                   alert_r;
  logic [7:0]             ptr_r;
  logic                   wr_en_r;
  logic [7:0]             wr_data_r;
  logic                   stat_rd_r;
  logic                   ara_done_r;

  function automatic logic ptr_valid(input logic [7:0] p);
    case (p)
      ssra_pkg::REG_STATUS, ssra_pkg::REG_CONFIG, ssra_pkg::REG_CONV,
      ssra_pkg::REG_Z2_HIGH, ssra_pkg::REG_Z2_LOW, ssra_pkg::REG_Z1_HIGH,
      ssra_pkg::REG_Z1_LOW, ssra_pkg::REG_Z1_TEMP, ssra_pkg::REG_Z2_TEMP: ptr_valid = 1'b1;
      default: ptr_valid = 1'b0;
    endcase
  endfunction

  logic [7:0] rd_data;

  always_comb begin
    case (ptr_r)
      ssra_pkg::REG_STATUS: begin
        rd_data = {meas.busy, 7'h00};
        rd_data[ssra_pkg::STAT_LSB +: ssra_pkg::FL_W] = stat_r;
      end
      ssra_pkg::REG_CONFIG:  rd_data = cfg_r;
      ssra_pkg::REG_CONV:    rd_data = conv_r;
      ssra_pkg::REG_Z2_HIGH: rd_data = z2_high_r;
      ssra_pkg::REG_Z2_LOW:  rd_data = z2_low_r;
      ssra_pkg::REG_Z1_HIGH: rd_data = z1_high_r;
      ssra_pkg::REG_Z1_LOW:  rd_data = z1_low_r;
      ssra_pkg::REG_Z1_TEMP: rd_data = z1_temp_r;
      ssra_pkg::REG_Z2_TEMP: rd_data = z2_temp_r;
      default:               rd_data = 8'h00;
    endcase
  end

  // Writes go to the register the pointer selects; read-only ones ignore them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_r     <= ssra_pkg::RST_CONFIG;
      conv_r    <= ssra_pkg::RST_CONV;
      z2_high_r <= ssra_pkg::RST_Z2_HIGH;
      z2_low_r  <= ssra_pkg::RST_Z2_LOW;
      z1_high_r <= ssra_pkg::RST_Z1_HIGH;
      z1_low_r  <= ssra_pkg::RST_Z1_LOW;
    end else if (wr_en_r) begin
      case (ptr_r)
        ssra_pkg::REG_CONFIG:  cfg_r     <= wr_data_r;
        ssra_pkg::REG_CONV:    conv_r    <= wr_data_r;
        ssra_pkg::REG_Z2_HIGH: z2_high_r <= wr_data_r;
        ssra_pkg::REG_Z2_LOW:  z2_low_r  <= wr_data_r;
        ssra_pkg::REG_Z1_HIGH: z1_high_r <= wr_data_r;
        ssra_pkg::REG_Z1_LOW:  z1_low_r  <= wr_data_r;
        default: ;
      endcase
    end
  end

  // ---------------- Limit checks and sticky status
  logic z1_hi;
  logic z1_lo;
  logic z2_hi;
  logic z2_lo;

  ssra_limit_cmp u_cmp_z1 (
    .temp            (meas.z1_temp[9:2]),
    .high_lim        (z1_high_r),
    .low_lim         (z1_low_r),
    .over_high       (z1_hi),
    .at_or_below_low (z1_lo)
  );

  ssra_limit_cmp u_cmp_z2 (
    .temp            (meas.z2_temp[9:2]),
    .high_lim        (z2_high_r),
    .low_lim         (z2_low_r),
    .over_high       (z2_hi),
    .at_or_below_low (z2_lo)
  );

  logic [ssra_pkg::FL_W-1:0] cond_new;
  logic [ssra_pkg::FL_W-1:0] stat_set;
  logic [ssra_pkg::FL_W-1:0] stat_clr;
  logic [ssra_pkg::FL_W-1:0] stat_nxt;

  always_comb begin
    cond_new                     = '0;
    cond_new[ssra_pkg::FL_ROPEN] = meas.diode_open;
    cond_new[ssra_pkg::FL_RLOW]  = z1_lo;
    cond_new[ssra_pkg::FL_RHIGH] = z1_hi;
    cond_new[ssra_pkg::FL_LLOW]  = z2_lo;
    cond_new[ssra_pkg::FL_LHIGH] = z2_hi;
    stat_set = meas_done ? cond_new : '0;
    stat_clr = stat_rd_r ? ~cond_r : '0;
    stat_nxt = (stat_r & ~stat_clr) | stat_set;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_r    <= '0;
      cond_r    <= '0;
      z1_temp_r <= ssra_pkg::RST_TEMP;
      z2_temp_r <= ssra_pkg::RST_TEMP;
    end else begin
      stat_r <= stat_nxt;
      if (meas_done) begin
        cond_r    <= cond_new;
        z1_temp_r <= meas.z1_temp[9:2];
        z2_temp_r <= meas.z2_temp[9:2];
      end
    end
  end

  // Alert latch: released only by an answered response with status already clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alert_r <= 1'b0;
    end else if ((|stat_set) || (|stat_r)) begin
      alert_r <= 1'b1;
    end else if (ara_done_r) begin
      alert_r <= 1'b0;
    end
  end

  logic alert_act;
  assign alert_act = alert_r & ~cfg_r[ssra_pkg::CFG_MASK_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= alert_act;
    end
  end

  assign alert_o = 1'b0;
  assign sda_o   = 1'b0;

  // ---------------- Serial state machine
  ssra_pkg::ssra_state_e st_r;
  ssra_pkg::ssra_state_e after_ack_r;
  logic [3:0]            cnt_r;
  logic [7:0]            sh_r;
  logic [7:0]            tx_r;
  logic                  ack_ph_r;
  logic                  ara_r;
  logic                  tx_stat_r;
  logic [7:0]            rx_byte;

  assign rx_byte = {sh_r[6:0], link_bit_r};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r        <= ssra_pkg::ST_IDLE;
      after_ack_r <= ssra_pkg::ST_IDLE;
      cnt_r       <= '0;
      sh_r        <= '0;
      tx_r        <= '0;
      ack_ph_r    <= 1'b0;
      ara_r       <= 1'b0;
      tx_stat_r   <= 1'b0;
      ptr_r       <= ssra_pkg::REG_STATUS;
      sda_oe      <= 1'b0;
      wr_en_r     <= 1'b0;
      wr_data_r   <= '0;
      stat_rd_r   <= 1'b0;
      ara_done_r  <= 1'b0;
    end else begin
      wr_en_r    <= 1'b0;
      stat_rd_r  <= 1'b0;
      ara_done_r <= 1'b0;
      if (tout_ev || stop_ev) begin
        st_r   <= ssra_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_ev) begin
        st_r   <= ssra_pkg::ST_ADDR;
        cnt_r  <= '0;
        sda_oe <= 1'b0;
      end else begin
        case (st_r)
          ssra_pkg::ST_IDLE: ;
          ssra_pkg::ST_ADDR, ssra_pkg::ST_PTR, ssra_pkg::ST_WDATA: begin
            if (bit_rx) begin
              sh_r  <= rx_byte;
              cnt_r <= cnt_r + 4'd1;
              if (cnt_r == ssra_pkg::BITS_PER_BYTE - 4'd1) begin
                st_r     <= ssra_pkg::ST_ACK;
                ack_ph_r <= 1'b0;
                if (st_r == ssra_pkg::ST_ADDR) begin
                  if (rx_byte[7:1] == ssra_pkg::OWN_ADDR) begin
                    ara_r       <= 1'b0;
                    after_ack_r <= rx_byte[0] ? ssra_pkg::ST_TX : ssra_pkg::ST_PTR;
                  end else if (rx_byte[7:1] == ssra_pkg::ARA_ADDR && rx_byte[0]
                               && alert_act) begin
                    ara_r       <= 1'b1;
                    after_ack_r <= ssra_pkg::ST_TX;
                  end else begin
                    st_r <= ssra_pkg::ST_IDLE;
                  end
                end else if (st_r == ssra_pkg::ST_PTR) begin
                  if (ptr_valid(rx_byte)) begin
                    ptr_r       <= rx_byte;
                    after_ack_r <= ssra_pkg::ST_WDATA;
                  end else begin
                    st_r <= ssra_pkg::ST_IDLE;
                  end
                end else begin
                  wr_en_r     <= 1'b1;
                  wr_data_r   <= rx_byte;
                  after_ack_r <= ssra_pkg::ST_WDATA;
                end
              end
            end
          end
          ssra_pkg::ST_ACK: begin
            if (scl_fall) begin
              if (!ack_ph_r) begin
                sda_oe   <= 1'b1;
                ack_ph_r <= 1'b1;
              end else begin
                ack_ph_r <= 1'b0;
                cnt_r    <= '0;
                st_r     <= after_ack_r;
                if (after_ack_r == ssra_pkg::ST_TX) begin
                  tx_r      <= ara_r ? ssra_pkg::ARA_REPLY : rd_data;
                  tx_stat_r <= !ara_r && (ptr_r == ssra_pkg::REG_STATUS);
                  sda_oe    <= ara_r ? ~ssra_pkg::ARA_REPLY[7] : ~rd_data[7];
                end else begin
                  sda_oe <= 1'b0;
                end
              end
            end
          end
          ssra_pkg::ST_TX: begin
            if (bit_rx) begin
              cnt_r <= cnt_r + 4'd1;
              if (ara_r && !sda_oe && !link_bit_r) begin
                st_r <= ssra_pkg::ST_IDLE;
              end
            end else if (scl_fall) begin
              if (cnt_r == ssra_pkg::BITS_PER_BYTE) begin
                sda_oe     <= 1'b0;
                st_r       <= ssra_pkg::ST_RACK;
                ara_done_r <= ara_r;
                stat_rd_r  <= tx_stat_r;
              end else begin
                tx_r   <= {tx_r[6:0], 1'b0};
                sda_oe <= ~tx_r[6];
              end
            end
          end
          ssra_pkg::ST_RACK: begin
            if (bit_rx) begin
              if (!link_bit_r && !ara_r) begin
                st_r        <= ssra_pkg::ST_ACK;
                ack_ph_r    <= 1'b1;
                after_ack_r <= ssra_pkg::ST_TX;
              end else begin
                st_r <= ssra_pkg::ST_IDLE;
              end
            end
          end
          default: st_r <= ssra_pkg::ST_IDLE;
        endcase
      end
    end
  end

endmodule

// ==== verification/ssra_checker.sv ====
// Port level assertions for the SMBus slave front end with alert logic
`timescale 1ns/1ps
module ssra_checker #(
  parameter int unsigned TIMEOUT_CYC = 2000
) (
  input wire logic                 clock,
  input wire logic                 rst,
  input wire logic                 scl,
  input wire logic                 sda_i,
  input wire logic                 sda_o,
  input wire logic                 sda_oe,
  input wire logic                 alert_i,
  input wire logic                 alert_o,
  input wire logic                 alert_oe,
  input wire logic                 meas_done,
  input wire ssra_pkg::ssra_meas_s meas
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int unsigned low_cnt;
  logic [7:0]  hi_cnt;
  logic [7:0]  since_low;
  logic [7:0]  since_meas;
  // Run lengths of bus levels and age of the last measurement
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt    <= 0;
      hi_cnt     <= 8'h00;
      since_low  <= 8'h00;
      since_meas <= 8'hFF;
    end else begin
      low_cnt    <= (!scl || !sda_i) ? low_cnt + 1 : 0;
      hi_cnt     <= !scl ? 8'h00 : (hi_cnt == 8'hFF ? hi_cnt : hi_cnt + 8'h01);
      since_low  <= !scl ? 8'h00 : (since_low == 8'hFF ? since_low : since_low + 8'h01);
      since_meas <= meas_done ? 8'h00 : (since_meas == 8'hFF ? since_meas : since_meas + 8'h01);
    end
  end
  property p_sda_change; $changed(sda_oe) |-> !scl; endproperty
  a_sda_change: assert property (p_sda_change) else $error("data moved with clock high");
  property p_open_drain; !sda_o && !alert_o; endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain output not low");
  property p_ack_width; $rose(sda_oe) |=> sda_oe [*8]; endproperty
  a_ack_width: assert property (p_ack_width) else $error("data pull too short");
  property p_idle_quiet; hi_cnt >= 8'd16 |-> !sda_oe; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("data pulled on idle bus");
  property p_timeout; low_cnt > TIMEOUT_CYC + 8 |-> !sda_oe; endproperty
  a_timeout: assert property (p_timeout) else $error("data held after bus timeout");
  property p_alert_hold; alert_oe && scl && $past(scl) |=> alert_oe; endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped off the bus");
  property p_alert_fall; $fell(alert_oe) |-> since_low < 8'd8; endproperty
  a_alert_fall: assert property (p_alert_fall) else $error("alert released off a bit");
  property p_alert_rise; $rose(alert_oe) |-> since_meas < 8'd8; endproperty
  a_alert_rise: assert property (p_alert_rise) else $error("alert without measurement");
  c_alert_set: cover property ($rose(alert_oe));
  c_alert_clr: cover property ($fell(alert_oe));
  c_timeout:   cover property (low_cnt == TIMEOUT_CYC);
  c_drive:     cover property ($rose(sda_oe));
endmodule

// ==== verification/ssra_host_model.sv ====
// Behavioural SMBus host that clocks the link and reports each byte it sees
`timescale 1ns/1ps
module ssra_host_model (
  output logic       scl,
  output logic       sda_pull,
  input  wire logic  sda,
  output logic [8:0] res,
  output logic       res_tgl
);
  localparam realtime H = 62.5;
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    res = 9'h000;
    res_tgl = 1'b0;
  end
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    #Q sda_pull = 1'b0;
    #Q scl = 1'b1;
    #H sda_pull = 1'b1;
    #H scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #H sda_pull = 1'b0;
    #(4*H);
  endtask
  task automatic bit_x(input logic b, output logic s);
    #Q sda_pull = !b;
    #Q scl = 1'b1;
    s = sda;
    #H scl = 1'b0;
  endtask
  // Ones in tx leave the line released, so a read sends all ones
  task automatic xfer(input logic [7:0] tx, input logic ack);
    logic [8:0] r;
    for (int i = 7; i >= 0; i--) bit_x(tx[i], r[i+1]);
    bit_x(ack, r[0]);
    res = r;
    res_tgl = !res_tgl;
  endtask
  task automatic hold_low(input realtime t);
    #t;
  endtask
endmodule

// ==== verification/ssra_bench.sv ====
// Self-checking bench for the SMBus slave front end with alert logic
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module ssra_bench;
  localparam int unsigned TOUT = 2000;
  logic                 clock, rst, meas_done, host_pull, res_tgl;
  logic                 sda_o, sda_oe, alert_o, alert_oe;
  logic [8:0]           res, e;
  logic [7:0]           x, y;
  ssra_pkg::ssra_meas_s meas;
  int                   fail_count, checked;
  logic [8:0]           exp_q[$];
  logic [7:0]           t1[5] = '{8'h60, 8'hF0, 8'h20, 8'h20, 8'h20};
  logic [7:0]           t2[5] = '{8'h20, 8'h20, 8'h60, 8'h00, 8'h20};
  logic [7:0]           st[5] = '{8'h10, 8'h08, 8'h40, 8'h20, 8'h04};
  wire                  scl;
  wire                  sda = !(sda_oe || host_pull);
  wire                  alert_n = !alert_oe;
  ssra_top #(.TIMEOUT_CYC(TOUT)) uut (.clock(clock), .rst(rst), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .alert_i(alert_n), .alert_o(alert_o),
    .alert_oe(alert_oe), .meas_done(meas_done), .meas(meas));
  ssra_host_model host (.scl(scl), .sda_pull(host_pull), .sda(sda), .res(res),
    .res_tgl(res_tgl));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic [7:0] b, input logic a);
    exp_q.push_back({b, a});
    host.xfer(b, 1'b1);
  endtask
  task automatic rb(input logic [7:0] v, input logic [7:0] tx);
    exp_q.push_back({v, 1'b1});
    host.xfer(tx, 1'b1);
  endtask
  task automatic rd_pre(input logic [7:0] v);
    host.start();
    wb(8'hB1, 1'b0);
    rb(v, 8'hFF);
    host.stop();
  endtask
  task automatic rd_reg(input logic [7:0] p, input logic [7:0] v);
    host.start();
    wb(8'hB0, 1'b0);
    wb(p, 1'b0);
    rd_pre(v);
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    host.start();
    wb(8'hB0, 1'b0);
    wb(p, 1'b0);
    wb(d, 1'b0);
    host.stop();
  endtask
  task automatic ara(input logic nack, input logic [7:0] tx, input logic [7:0] v);
    host.start();
    wb(8'h19, nack);
    if (!nack) rb(v, tx);
    host.stop();
  endtask
  task automatic put_meas(input logic [7:0] z1, input logic [7:0] z2, input logic op);
    @(posedge clock);
    meas <= {z1, 2'b00, z2, 2'b00, op, 1'b0};
    meas_done <= 1'b1;
    @(posedge clock);
    meas_done <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  // Each reported byte is matched against the oldest expectation
  initial forever begin
    @(res_tgl);
    if (exp_q.size() == 0) begin
      fail_count++;
      $display("ERROR %0t: unexpected byte", $time);
    end else begin
      e = exp_q.pop_front();
      `CHK(res, e)
    end
  end
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    meas_done = 1'b0;
    meas = '0;
    void'($urandom(13669));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    host.start();
    wb(8'hB1, 1'b0);
    host.hold_low(200.0);
    `CHK(sda_oe, 1'b1)
    host.hold_low(TOUT * 10.0 + 1000.0);
    `CHK(sda_oe, 1'b0)
    host.stop();
    rd_reg(8'h0A, ssra_pkg::RST_CONV);
    rd_pre(ssra_pkg::RST_CONV);
    x = 8'($urandom);
    y = 8'($urandom);
    host.start();
    wb(8'hB0, 1'b0);
    wb(8'h0A, 1'b0);
    wb(x, 1'b0);
    wb(y, 1'b0);
    host.stop();
    rd_pre(y);
    // Master acknowledges the first byte, so the same register is sent again
    host.start();
    wb(8'hB1, 1'b0);
    exp_q.push_back({y, 1'b0});
    host.xfer(8'hFF, 1'b0);
    rb(y, 8'hFF);
    host.stop();
    host.start();
    wb({2'b11, x[4:0], 1'b0}, 1'b1);
    wb(8'h00, 1'b1);
    host.stop();
    host.start();
    wb(8'hB0, 1'b0);
    wb(8'h03, 1'b1);
    host.stop();
    rd_pre(y);
    ara(1'b1, 8'hFF, 8'h00);
    for (int i = 0; i < 5; i++) begin
      put_meas(t1[i], t2[i], i == 4);
      `CHK(alert_oe, 1'b1)
      if (i == 0) begin
        ara(1'b0, 8'h9F, 8'h9F);
        `CHK(alert_oe, 1'b1)
      end
      rd_reg(8'h02, st[i]);
      put_meas(8'h20, 8'h20, 1'b0);
      rd_pre(st[i]);
      rd_pre(8'h00);
      `CHK(alert_oe, 1'b1)
      ara(1'b0, 8'hFF, ssra_pkg::ARA_REPLY);
      `CHK(alert_oe, 1'b0)
    end
    wr_reg(8'h09, 8'h80);
    put_meas(8'h60, 8'h20, 1'b0);
    `CHK(alert_oe, 1'b0)
    ara(1'b1, 8'hFF, 8'h00);
    rd_reg(8'h02, 8'h10);
    repeat (20) @(posedge clock);
    if (exp_q.size() != 0) fail_count++;
    print_verdict();
  end
endmodule
bind ssra_top ssra_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.clock(clock), .rst(rst),
  .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .alert_i(alert_i),
  .alert_o(alert_o), .alert_oe(alert_oe), .meas_done(meas_done), .meas(meas));
